// ==== core/rav_cfg.svh ====
// Constants for the recorded analogue section framer
`ifndef RAV_CFG_SVH
`define RAV_CFG_SVH
`define RAV_WORD 32
`define RAV_AW 8
`define RAV_REG_CTRL 8'h00
`define RAV_REG_STAT 8'h04
`define RAV_REG_TIME_LO 8'h08
`define RAV_REG_TIME_HI 8'h0c
`define RAV_REG_IVAL 8'h10
`define RAV_REG_RECID 8'h14
`define RAV_REG_COUNT 8'h18
`define RAV_REG_ELEM_HI 8'h1c
`define RAV_REG_ELEM_LO 8'h20
`define RAV_REG_IVMS 8'h24
`define RAV_CTRL_START 0
`define RAV_CTRL_CLEAR 1
`define RAV_CTRL_KIND 3:2
`define RAV_STAT_DONE 1
`define RAV_KIND_RST 2'h0
`define RAV_TIME_W 56
`define RAV_TIME_HI_W 24
`define RAV_HDR_LEN 4'hd
`define RAV_SEG_MAX 8'hf0
`define RAV_SECT_MAX 17'hfa00
`define RAV_MEM_W 40
`define RAV_MEM_D 256
`define RAV_CNT_W 9
`define RAV_ELEN_NVA 3'h2
`define RAV_ELEN_NVQ 3'h3
`define RAV_ELEN_BCR 3'h5
`define RAV_QUAL_UNUSED 2'h0
`define RAV_QUAL_NVA 2'h1
`define RAV_QUAL_BCR 2'h2
`define RAV_QUAL_PRIV 2'h3
`define RAV_FACTOR_UNUSED 8'h00
`define RAV_TB_1MS 8'h01
`define RAV_TB_10MS 8'h02
`define RAV_TB_100MS 8'h03
`define RAV_TB_1S 8'h04
`define RAV_TB_1MIN 8'h05
`define RAV_TB_1H 8'h06
`define RAV_MS_1MS 32'h1
`define RAV_MS_10MS 32'ha
`define RAV_MS_100MS 32'h64
`define RAV_MS_1S 32'h3e8
`define RAV_MS_1MIN 32'hea60
`define RAV_MS_1H 32'h36ee80
`endif

// ==== core/rav_pkg.sv ====
// Types shared by the recorded analogue section framer
package rav_pkg;
	typedef enum logic [1:0] {RAV_NVA, RAV_NVQ, RAV_BCR} rav_kind_t;
	typedef enum logic [1:0] {
		RAV_S_IDLE,
		RAV_S_HDR,
		RAV_S_FETCH,
		RAV_S_ELEM
	} rav_state_t;
	// Interval word, factor in the low octet
	typedef struct packed {
		logic [7:0] tbase;
		logic [7:0] factor;
	} rav_ival_t;
	// Record id, address in the low 14 bits
	typedef struct packed {
		logic [1:0] qual;
		logic [13:0] addr;
	} rav_recid_t;
	// Section header, first octet in the low byte
	typedef struct packed {
		logic [15:0] count;
		rav_recid_t recid;
		rav_ival_t ival;
		logic [55:0] start_time;
	} rav_hdr_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic seg_first;
		logic seg_last;
		logic sect_end;
	} rav_stream_t;
endpackage

// ==== core/rav_mem.sv ====
// Element store with registered read data
`timescale 1ns/1ps
`include "rav_cfg.svh"
module rav_mem (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic we_i,
	input wire logic [`RAV_AW-1:0] waddr_i,
	input wire logic [`RAV_MEM_W-1:0] wdata_i,
	input wire logic re_i,
	input wire logic [`RAV_AW-1:0] raddr_i,
	output logic [`RAV_MEM_W-1:0] rdata_o
);
	logic [`RAV_MEM_W-1:0] mem [`RAV_MEM_D];

	// Write port
	always_ff @(posedge clk_i) begin
		if (ce_i && we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// Registered read port
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= '0;
		end else if (ce_i && re_i) begin
			rdata_o <= mem[raddr_i];
		end
	end
endmodule

// ==== core/rav_framer.sv ====
// Recorded analogue section framer: registers, header and segment stream
`timescale 1ns/1ps
`include "rav_cfg.svh"
module rav_framer
	import rav_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [`RAV_AW-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [31:0] rdata_o,
	input wire logic out_ready_i,
	output rav_stream_t out_o,
	output logic busy_o,
	output logic done_o,
	output logic not_ready_o
);
	////////////////////////////////////////////////////////////////////
	// Declarations
	logic [1:0] kind_q;
	logic [`RAV_TIME_W-1:0] time_q;
	rav_ival_t ival_q;
	rav_recid_t recid_q;
	logic [7:0] elem_hi_q;
	logic [`RAV_CNT_W-1:0] elem_cnt_q;
	logic [31:0] ivms_q;
	logic [7:0] sect_cnt_q;
	logic busy_q, done_q, not_ready_q;
	rav_state_t state_q;
	logic [3:0] hdr_idx_q;
	logic [2:0] byte_idx_q;
	logic [`RAV_CNT_W-1:0] elem_idx_q;
	logic [7:0] seg_cnt_q;
	rav_stream_t out_q;
	logic [31:0] rdata_q, rd_mux;
	logic [`RAV_MEM_W-1:0] mem_rdata;
	rav_hdr_t hdr;
	logic [2:0] elen;
	logic [16:0] sect_len;
	logic start_req, clr_req, stat_clr, push, full;
	logic bad, start_ok, refuse;
	logic load, last_hdr, last_byte, sect_last, seg_full;
	logic [7:0] byte_d;

	////////////////////////////////////////////////////////////////////
	// Bus decode
	assign start_req = we_i && addr_i == `RAV_REG_CTRL
		&& wdata_i[`RAV_CTRL_START];
	assign clr_req = we_i && addr_i == `RAV_REG_CTRL
		&& wdata_i[`RAV_CTRL_CLEAR];
	assign stat_clr = we_i && addr_i == `RAV_REG_STAT
		&& wdata_i[`RAV_STAT_DONE];
	assign full = elem_cnt_q == `RAV_CNT_W'(`RAV_MEM_D);
	// Elements only accepted while idle and not full
	assign push = we_i && addr_i == `RAV_REG_ELEM_LO && !busy_q && !full;

	// Software writable configuration, locked during a build
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			kind_q <= `RAV_KIND_RST;
			time_q <= '0;
			ival_q <= '0;
			recid_q <= '0;
			elem_hi_q <= '0;
		end else if (ce_i && we_i && !busy_q) begin
			case (addr_i)
				`RAV_REG_CTRL: kind_q <= wdata_i[`RAV_CTRL_KIND];
				`RAV_REG_TIME_LO: time_q[`RAV_WORD-1:0] <= wdata_i;
				`RAV_REG_TIME_HI: begin
					time_q[`RAV_TIME_W-1:`RAV_WORD] <=
						wdata_i[`RAV_TIME_HI_W-1:0];
				end
				`RAV_REG_IVAL: ival_q <= wdata_i[15:0];
				`RAV_REG_RECID: recid_q <= wdata_i[15:0];
				`RAV_REG_ELEM_HI: elem_hi_q <= wdata_i[7:0];
				default: ;
			endcase
		end
	end

	// Element count follows the elements actually stored
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			elem_cnt_q <= '0;
		end else if (ce_i) begin
			if (clr_req && !busy_q) begin
				elem_cnt_q <= '0;
			end else if (push) begin
				elem_cnt_q <= elem_cnt_q + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interval decode
	function automatic logic [31:0] base_ms(input logic [7:0] tb);
		case (tb)
			`RAV_TB_1MS: base_ms = `RAV_MS_1MS;
			`RAV_TB_10MS: base_ms = `RAV_MS_10MS;
			`RAV_TB_100MS: base_ms = `RAV_MS_100MS;
			`RAV_TB_1S: base_ms = `RAV_MS_1S;
			`RAV_TB_1MIN: base_ms = `RAV_MS_1MIN;
			`RAV_TB_1H: base_ms = `RAV_MS_1H;
			default: base_ms = '0; // Unused, reserved, private
		endcase
	endfunction

	// Spacing in ms, zero where no standard duration exists
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ivms_q <= '0;
		end else if (ce_i) begin
			ivms_q <= `RAV_WORD'(ival_q.factor * base_ms(ival_q.tbase));
		end
	end

	////////////////////////////////////////////////////////////////////
	// Section checks
	always_comb begin
		unique case (kind_q)
			RAV_NVA: elen = `RAV_ELEN_NVA;
			RAV_NVQ: elen = `RAV_ELEN_NVQ;
			RAV_BCR: elen = `RAV_ELEN_BCR;
			default: elen = `RAV_ELEN_BCR;
		endcase
	end
	assign sect_len = 17'(`RAV_HDR_LEN) + 17'(elem_cnt_q) * 17'(elen);
	// Kind must match qualifier; unused factor and qualifier codes refused, time base code not checked
	assign bad = ival_q.factor == `RAV_FACTOR_UNUSED
		|| recid_q.qual == `RAV_QUAL_UNUSED
		|| recid_q.qual == `RAV_QUAL_PRIV
		|| kind_q == 2'h3
		|| (recid_q.qual == `RAV_QUAL_NVA && kind_q == RAV_BCR)
		|| (recid_q.qual == `RAV_QUAL_BCR && kind_q != RAV_BCR)
		|| sect_len > `RAV_SECT_MAX;
	assign start_ok = start_req && !busy_q && !bad;
	assign refuse = start_req && !busy_q && bad;

	// Header assembled in payload order, first octet lowest
	assign hdr.start_time = time_q;
	assign hdr.ival = ival_q;
	assign hdr.recid = recid_q; // Names the sequence as given
	assign hdr.count = 16'(elem_cnt_q);

	////////////////////////////////////////////////////////////////////
	// Byte sequencing
	assign load = (state_q == RAV_S_HDR || state_q == RAV_S_ELEM)
		&& (!out_q.valid || out_ready_i);
	assign last_hdr = hdr_idx_q == `RAV_HDR_LEN - 4'h1;
	assign last_byte = byte_idx_q == elen - 3'h1;
	assign seg_full = seg_cnt_q == `RAV_SEG_MAX - 8'h1;
	assign sect_last = (state_q == RAV_S_HDR && last_hdr
		&& elem_cnt_q == '0) || (state_q == RAV_S_ELEM && last_byte
		&& elem_idx_q == elem_cnt_q - 1'b1);

	// Current byte from header or element
	always_comb begin
		byte_d = '0;
		if (state_q == RAV_S_HDR) begin
			byte_d = hdr[hdr_idx_q * 8 +: 8];
		end else begin
			byte_d = mem_rdata[byte_idx_q * 8 +: 8];
		end
	end

	// Walk header, then each element in sampling order
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= RAV_S_IDLE;
			hdr_idx_q <= '0;
			byte_idx_q <= '0;
			elem_idx_q <= '0;
		end else if (ce_i) begin
			unique case (state_q)
				RAV_S_IDLE: begin
					if (start_ok) begin
						state_q <= RAV_S_HDR;
						hdr_idx_q <= '0;
						elem_idx_q <= '0;
					end
				end
				RAV_S_HDR: begin
					if (load) begin
						hdr_idx_q <= hdr_idx_q + 4'h1;
						if (last_hdr) begin
							state_q <= sect_last ? RAV_S_IDLE : RAV_S_FETCH;
						end
					end
				end
				RAV_S_FETCH: begin
					state_q <= RAV_S_ELEM;
					byte_idx_q <= '0;
				end
				RAV_S_ELEM: begin
					if (load) begin
						byte_idx_q <= byte_idx_q + 3'h1;
						if (last_byte) begin
							elem_idx_q <= elem_idx_q + 1'b1;
							state_q <= sect_last ? RAV_S_IDLE : RAV_S_FETCH;
						end
					end
				end
			endcase
		end
	end

	// Octets within the current segment
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			seg_cnt_q <= '0;
		end else if (ce_i) begin
			if (start_ok) begin
				seg_cnt_q <= '0; // Payload opens a segment
			end else if (load) begin
				seg_cnt_q <= (seg_full || sect_last) ? '0
					: seg_cnt_q + 8'h1;
			end
		end
	end

	// Output stage, holds while the sink stalls
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			out_q <= '0;
		end else if (ce_i) begin
			if (load) begin
				out_q.valid <= 1'b1;
				out_q.data <= byte_d;
				out_q.seg_first <= seg_cnt_q == '0;
				out_q.seg_last <= seg_full || sect_last;
				out_q.sect_end <= sect_last;
			end else if (out_ready_i) begin
				out_q.valid <= 1'b0;
			end
		end
	end

	rav_mem u_mem (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.we_i(push),
		.waddr_i(elem_cnt_q[`RAV_AW-1:0]),
		.wdata_i({elem_hi_q, wdata_i}),
		.re_i(state_q == RAV_S_FETCH),
		.raddr_i(elem_idx_q[`RAV_AW-1:0]),
		.rdata_o(mem_rdata)
	);

	////////////////////////////////////////////////////////////////////
	// Status
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			not_ready_q <= 1'b0;
			sect_cnt_q <= '0;
		end else if (ce_i) begin
			if (start_ok) begin
				busy_q <= 1'b1;
			end else if (state_q == RAV_S_IDLE && !out_q.valid) begin
				busy_q <= 1'b0;
			end
			// Completion wins over a clear in the same cycle
			if (load && sect_last) begin
				done_q <= 1'b1;
				sect_cnt_q <= sect_cnt_q + 8'h1;
			end else if (stat_clr || start_ok) begin
				done_q <= 1'b0;
			end
			if (refuse) begin
				not_ready_q <= 1'b1;
			end else if (start_ok) begin
				not_ready_q <= 1'b0;
			end
		end
	end

	// Read mux
	always_comb begin
		rd_mux = '0;
		case (addr_i)
			`RAV_REG_CTRL: rd_mux = `RAV_WORD'({kind_q, 2'h0});
			`RAV_REG_STAT: begin
				rd_mux = `RAV_WORD'({sect_cnt_q, 4'h0, full, not_ready_q,
					done_q, busy_q});
			end
			`RAV_REG_TIME_LO: rd_mux = time_q[`RAV_WORD-1:0];
			`RAV_REG_TIME_HI: begin
				rd_mux = `RAV_WORD'(time_q[`RAV_TIME_W-1:`RAV_WORD]);
			end
			`RAV_REG_IVAL: rd_mux = `RAV_WORD'(ival_q);
			`RAV_REG_RECID: rd_mux = `RAV_WORD'(recid_q);
			`RAV_REG_COUNT: rd_mux = `RAV_WORD'(elem_cnt_q);
			`RAV_REG_ELEM_HI: rd_mux = `RAV_WORD'(elem_hi_q);
			`RAV_REG_IVMS: rd_mux = ivms_q;
			default: rd_mux = '0;
		endcase
	end

	// Read data valid one cycle after the strobe only
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_q <= '0;
		end else if (ce_i) begin
			rdata_q <= re_i ? rd_mux : '0;
		end
	end

	assign rdata_o = rdata_q;
	assign out_o = out_q;
	assign busy_o = busy_q;
	assign done_o = done_q;
	assign not_ready_o = not_ready_q;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	a_refuse_unused: assert property (
		ce_i && refuse |=> not_ready_q && !busy_q && state_q == RAV_S_IDLE)
		else $error("bad section not refused");
	a_seg_octet_bound: assert property (
		seg_cnt_q < `RAV_SEG_MAX && (out_q.seg_last || !out_q.sect_end))
		else $error("segment longer than limit");
	a_first_octet_time: assert property (
		ce_i && start_ok ##1 (ce_i && load)[*1] |=> out_q.seg_first
		&& out_q.data == $past(time_q[7:0], 2))
		else $error("payload does not open with start time");
	a_ival_in_header: assert property (
		ce_i && load && state_q == RAV_S_HDR && hdr_idx_q == 4'h8
		|=> out_q.data == ival_q.tbase)
		else $error("interval high octet misplaced");
	a_count_frozen: assert property (
		busy_q |=> $stable(elem_cnt_q))
		else $error("element count moved during build");
	a_elem_order: assert property (
		$changed(elem_idx_q) |-> elem_idx_q == '0
		|| elem_idx_q == $past(elem_idx_q) + 1'b1)
		else $error("elements out of order");
	a_kind_match: assert property (
		busy_q && recid_q.qual == `RAV_QUAL_BCR |-> kind_q == RAV_BCR)
		else $error("kind differs from qualifier");
	a_minute_base: assert property (
		ce_i && ival_q.tbase == `RAV_TB_1MIN |=>
		ivms_q == `RAV_WORD'($past(ival_q.factor) * `RAV_MS_1MIN))
		else $error("minute interval decoded wrong");
	a_private_base: assert property (
		ce_i && ival_q.tbase > `RAV_TB_1H |=> ivms_q == '0)
		else $error("reserved time base given a duration");
	a_end_drains: assert property (
		ce_i && load && sect_last ##1 ce_i[*2] |-> ##[0:4] done_q)
		else $error("section end not reported");

	c_section_done: cover property (ce_i && load && sect_last);
	c_refused: cover property (ce_i && refuse);
	c_segment_split: cover property (ce_i && load && seg_full
		&& !sect_last);
	c_sink_stall: cover property (out_q.valid && !out_ready_i [*3]);
endmodule

// ==== dv/rav_sink.sv ====
// Stream sink standing for the link side: random stalls, records octets
`timescale 1ns/1ps
module rav_sink
	import rav_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire rav_stream_t out_i,
	output logic out_ready_o
);
	integer seed = 32'h6a18;
	logic [10:0] got[$];
	////////////////////////////////////////////////////////////////
	// Ready held low about a quarter of the cycles
	always @(posedge clk_i) begin
		out_ready_o <= (($random(seed) & 3) != 0);
	end
	// Take an octet only where the framer sees the handshake
	always @(posedge clk_i) begin
		if (reset_n_i && ce_i && out_i.valid === 1'b1 && out_ready_o) begin
			got.push_back({out_i.data, out_i.seg_first, out_i.seg_last,
				out_i.sect_end});
		end
	end
	initial out_ready_o = 1'b0;
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the recorded analogue section framer
`timescale 1ns/1ps
`include "rav_cfg.svh"
module tb_top;
	import rav_pkg::*;
	logic clk_i = 0;
	logic reset_n_i = 0;
	logic ce_i = 1;
	logic we_i = 0;
	logic re_i = 0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic [31:0] rdata_o;
	logic out_ready_i;
	rav_stream_t out_o;
	logic busy_o, done_o, not_ready_o;
	integer seed = 32'h6a18;
	int n_fail = 0;
	int total_checks = 0;
	logic stream_on = 0;
	logic [39:0] el[0:256];
	logic [7:0] bad[6][3];
	////////////////////////////////////////////////////////////////
	// Clock, and clock enable dropped at random while streaming
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		ce_i <= stream_on ? (($random(seed) & 3) != 0) : 1'b1;
	end
	rav_framer dut(.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
		.rdata_o(rdata_o), .out_ready_i(out_ready_i), .out_o(out_o),
		.busy_o(busy_o), .done_o(done_o), .not_ready_o(not_ready_o));
	rav_sink sink(.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
		.out_i(out_o), .out_ready_o(out_ready_i));
	////////////////////////////////////////////////////////////////
	// Verdict and run end
	task tally_and_finish();
		if (n_fail == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task check(input string name, input logic [31:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Register bus cycles
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		we_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		@(posedge clk_i);
		re_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		re_i <= 1'b0;
		@(negedge clk_i);
		check(name, exp, rdata_o);
	endtask
	// Spacing in ms for a time base code, zero where none is defined
	function automatic logic [31:0] base_ms(input logic [7:0] c);
		case (c)
			8'h01: return 32'd1;
			8'h02: return 32'd10;
			8'h03: return 32'd100;
			8'h04: return 32'd1000;
			8'h05: return 32'd60000;
			8'h06: return 32'd3600000;
			default: return 32'd0;
		endcase
	endfunction
	// Load, build and stream one section, then compare every octet
	task run(input logic [1:0] k, input int p);
		logic [55:0] t;
		logic [15:0] iv, rid;
		logic [103:0] hdr;
		logic [7:0] b[$];
		logic [10:0] e;
		int n, len;
		b.delete();
		t = {$random(seed), $random(seed)};
		iv = 16'($random(seed)) | 16'h0001;
		rid = {(k == 2'h2) ? 2'h2 : 2'h1, 14'($random(seed))};
		n = (p > 256) ? 256 : p;
		len = (k == 2'h0) ? 2 : (k == 2'h1) ? 3 : 5;
		wr(`RAV_REG_CTRL, {28'h0, k, 2'b10});
		wr(`RAV_REG_TIME_LO, t[31:0]);
		wr(`RAV_REG_TIME_HI, {8'h0, t[55:32]});
		wr(`RAV_REG_IVAL, {16'h0, iv});
		wr(`RAV_REG_RECID, {16'h0, rid});
		for (int i = 0; i < p; i++) begin
			el[i] = 40'({$random(seed), $random(seed)});
			wr(`RAV_REG_ELEM_HI, {24'h0, el[i][39:32]});
			wr(`RAV_REG_ELEM_LO, el[i][31:0]);
		end
		hdr = {16'(n), rid, iv, t};
		for (int j = 0; j < 13; j++) b.push_back(hdr[8*j +: 8]);
		for (int i = 0; i < n; i++) begin
			for (int j = 0; j < len; j++) b.push_back(el[i][8*j +: 8]);
		end
		sink.got.delete();
		// Start stands for the file select; taken before ce goes random
		wr(`RAV_REG_CTRL, {28'h0, k, 2'b01});
		stream_on = 1'b1;
		@(negedge clk_i);
		for (int w = 0; w < 6000 && !(done_o === 1'b1 && busy_o === 1'b0);
			w++) @(negedge clk_i);
		stream_on = 1'b0;
		check("done", 32'h1, {31'h0, done_o});
		check("not_ready", 32'h0, {31'h0, not_ready_o});
		check("octets", b.size(), sink.got.size());
		for (int i = 0; i < b.size() && i < sink.got.size(); i++) begin
			e = {b[i], i % 240 == 0, i % 240 == 239 || i == b.size() - 1,
				i == b.size() - 1};
			check("octet", {21'h0, e}, {21'h0, sink.got[i]});
		end
		rd(`RAV_REG_COUNT, n, "count");
	endtask
	////////////////////////////////////////////////////////////////
	// Watchdog against a hung stream
	initial begin
		repeat (60000) @(posedge clk_i);
		n_fail++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		bad = '{'{0, 1, 0}, '{5, 0, 0}, '{5, 3, 0}, '{5, 1, 3}, '{5, 1, 2},
			'{5, 2, 0}};
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd(`RAV_REG_STAT, 32'h0, "stat reset");
		rd(8'h3c, 32'h0, "unmapped");
		// Time base codes across defined, reserved and private ranges
		for (int i = 0; i < 10; i++) begin
			automatic logic [7:0] c = (i < 8) ? 8'(i)
				: (i == 8) ? 8'h10 : 8'hff;
			wr(`RAV_REG_IVAL, {16'h0, c, 8'h01});
			rd(`RAV_REG_IVMS, base_ms(c), "ivms");
		end
		wr(`RAV_REG_IVAL, {16'h0, 8'h02, 8'h03});
		rd(`RAV_REG_IVMS, 32'd30, "ivms product");
		// One refused start per factor, qualifier and kind rule; section length limit not driven
		for (int i = 0; i < 6; i++) begin
			wr(`RAV_REG_CTRL, {28'h0, bad[i][2][1:0], 2'b10});
			wr(`RAV_REG_IVAL, {16'h0, 8'h01, bad[i][0]});
			wr(`RAV_REG_RECID, {16'h0, bad[i][1][1:0], 14'h0});
			wr(`RAV_REG_CTRL, {28'h0, bad[i][2][1:0], 2'b01});
			@(negedge clk_i);
			check("not_ready", 32'h1, {31'h0, not_ready_o});
			check("busy", 32'h0, {31'h0, busy_o});
		end
		// Corner sections: each kind, empty, segment crossing, full store
		run(2'h0, 7);
		run(2'h1, 0);
		run(2'h2, 60);
		run(2'h1, 100);
		run(2'h2, 257);
		for (int i = 0; i < 3; i++) begin
			run(2'(($random(seed) & 32'h7fff) % 3),
				($random(seed) & 63) + 1);
		end
		tally_and_finish();
	end
endmodule
